// >>> verilog/amp_datapath.sv
// accumulator multiply-accumulate datapath with x/y operand prefetch
`timescale 1ns/1ps
`include "amp_params.svh"
module amp_datapath import amp_pkg::*; #(
    parameter int DW = `AMP_DATA_W,
    parameter int AW = `AMP_ACC_W
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // operation issue
    input wire logic i_op_valid,
    input wire amp_op_t i_op,
    input wire logic i_acc_sel,
    input wire logic [`AMP_IDX_W-1:0] i_src_a,
    input wire logic [`AMP_IDX_W-1:0] i_src_b,
    input wire logic [`AMP_SHIFT_W-1:0] i_shift,
    input wire logic [2*DW-1:0] i_dividend,
    input wire logic [`AMP_EXT_ADDR_W-1:0] i_ext_addr,
    input wire logic [DW-1:0] i_ptr_value,
    // prefetch and write-back controls
    input wire logic i_x_en,
    input wire logic [`AMP_INC_CODE_W-1:0] i_x_incr,
    input wire logic [DW-1:0] i_x_incr_value,
    input wire logic [`AMP_IDX_W-1:0] i_x_dest,
    input wire logic i_y_en,
    input wire logic [`AMP_INC_CODE_W-1:0] i_y_incr,
    input wire logic [DW-1:0] i_y_incr_value,
    input wire logic [`AMP_IDX_W-1:0] i_y_dest,
    input wire logic i_wb_en,
    input wire logic [`AMP_IDX_W-1:0] i_wb_dest,
    // x and y data memories
    output logic o_xmem_rd,
    output logic [DW-1:0] o_xmem_addr,
    input wire logic [DW-1:0] i_xmem_data,
    output logic o_ymem_rd,
    output logic [DW-1:0] o_ymem_addr,
    input wire logic [DW-1:0] i_ymem_data,
    // status and results
    output logic o_ready,
    output logic o_done,
    output logic [DW-1:0] o_result,
    output logic [AW-1:0] o_acc_a,
    output logic [AW-1:0] o_acc_b
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        amp_state_t st; // sequencer state
        amp_op_t op; // latched operation
        logic acc_sel; // target accumulator
        logic [`AMP_IDX_W-1:0] src_a; // first operand index
        logic [`AMP_IDX_W-1:0] src_b; // second operand index
        logic [`AMP_SHIFT_W-1:0] shift; // load shift amount
        logic [2*DW-1:0] dividend; // latched dividend
        logic [`AMP_EXT_ADDR_W-1:0] ext; // latched extended address
        logic [DW-1:0] ptr_val; // latched pointer value
        logic x_en; // x prefetch requested
        logic [`AMP_IDX_W-1:0] x_dest; // x word / distance target
        logic y_en; // y prefetch requested
        logic [`AMP_IDX_W-1:0] y_dest; // y word target
        logic wb_en; // write-back requested
        logic [`AMP_IDX_W-1:0] wb_dest; // write-back target
        logic [AW-1:0] acc_a; // accumulator a
        logic [AW-1:0] acc_b; // accumulator b
        logic [`AMP_NREG-1:0][DW-1:0] wreg; // working registers
        logic [DW-1:0] x_ptr; // x prefetch pointer
        logic [DW-1:0] y_ptr; // y prefetch pointer
        logic [DW-1:0] result; // word result
        logic done; // completion pulse
    } amp_regs_t;

    amp_regs_t state_reg;
    amp_regs_t state_next;

    // ****************************************************************
    // helpers
    // ****************************************************************
    // decode a step code; code 7 takes the register-held integer
    function automatic logic [DW-1:0] step_of(input logic [`AMP_INC_CODE_W-1:0] code,
                                               input logic [DW-1:0] value);
        logic [DW-1:0] lit;
        lit = DW'({code, 1'h0}) - `AMP_INC_BIAS;
        step_of = (code == `AMP_INC_CODE_REG) ? value : lit;
    endfunction

    // position from the msb end of the first bit unlike the sign; DW if none
    function automatic logic [DW-1:0] first_change(input logic [DW-1:0] v);
        logic [DW-1:0] pos;
        pos = DW'(DW);
        for (int i = 0; i < DW - 1; i++) begin
            if (v[i] != v[DW-1]) begin
                pos = DW'(DW - 1 - i); // lower bits visited first, msb-most wins
            end
        end
        first_change = pos;
    endfunction

    // ****************************************************************
    // datapath arithmetic
    // ****************************************************************
    logic [DW-1:0] opnd_a; // first operand word
    logic [DW-1:0] opnd_b; // second operand word
    logic [2*DW-1:0] product; // signed product or square
    logic [AW-1:0] prod_ext; // product widened to accumulator
    logic [AW-1:0] acc_sel_val; // current target accumulator
    logic [AW-1:0] acc_other; // accumulator not targeted
    logic [AW-1:0] lac_val; // shifted load value
    logic [2*DW-1:0] rem_s; // signed remainder
    logic [2*DW-1:0] rem_u; // unsigned remainder
    logic [2*DW-1:0] divisor_s; // sign-extended divisor
    logic [DW-1:0] diff; // x word minus y word

    always_comb begin
        opnd_a = state_reg.wreg[state_reg.src_a];
        opnd_b = state_reg.wreg[state_reg.src_b];
        // squares reuse the multiplier with both inputs tied to one operand
        if (state_reg.op == AMP_OP_SQR || state_reg.op == AMP_OP_SQRAC) begin
            product = $signed(opnd_a) * $signed(opnd_a);
        end else begin
            product = $signed(opnd_a) * $signed(opnd_b);
        end
        prod_ext = {{(AW-2*DW){product[2*DW-1]}}, product};
        acc_sel_val = state_reg.acc_sel ? state_reg.acc_b : state_reg.acc_a;
        acc_other = state_reg.acc_sel ? state_reg.acc_a : state_reg.acc_b;
        // positive shift moves right (arithmetic), negative moves left
        if (state_reg.shift[`AMP_SHIFT_W-1]) begin
            lac_val = {{(AW-DW){opnd_a[DW-1]}}, opnd_a} << (-state_reg.shift);
        end else begin
            lac_val = $signed({{(AW-DW){opnd_a[DW-1]}}, opnd_a}) >>> state_reg.shift;
        end
        // zero divisor forces a zero remainder; 16-bit quotient overflow does not affect the full-width remainder
        divisor_s = {{DW{opnd_a[DW-1]}}, opnd_a};
        if (opnd_a == `AMP_WORD_RESET) begin
            rem_s = '0;
            rem_u = '0;
        end else begin
            rem_s = $signed(state_reg.dividend) % $signed(divisor_s);
            rem_u = state_reg.dividend % {{DW{1'h0}}, opnd_a};
        end
        diff = i_xmem_data - i_ymem_data;
    end

    // ****************************************************************
    // memory requests and handshake
    // ****************************************************************
    // reads are issued on the accepting edge; data returns one cycle later
    always_comb begin
        o_ready = (state_reg.st == AMP_ST_IDLE);
        o_xmem_rd = o_ready && i_op_valid && i_x_en;
        o_ymem_rd = o_ready && i_op_valid && i_y_en;
        o_xmem_addr = state_reg.x_ptr;
        o_ymem_addr = state_reg.y_ptr;
        o_done = state_reg.done;
        o_result = state_reg.result;
        o_acc_a = state_reg.acc_a;
        o_acc_b = state_reg.acc_b;
    end

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        state_next.done = 1'h0;
        case (state_reg.st)
            AMP_ST_IDLE: begin
                if (i_op_valid) begin
                    state_next.st = AMP_ST_EXEC;
                    state_next.op = i_op;
                    state_next.acc_sel = i_acc_sel;
                    state_next.src_a = i_src_a;
                    state_next.src_b = i_src_b;
                    state_next.shift = i_shift;
                    state_next.dividend = i_dividend;
                    state_next.ext = i_ext_addr;
                    state_next.ptr_val = i_ptr_value;
                    state_next.x_en = i_x_en;
                    state_next.x_dest = i_x_dest;
                    state_next.y_en = i_y_en;
                    state_next.y_dest = i_y_dest;
                    state_next.wb_en = i_wb_en;
                    state_next.wb_dest = i_wb_dest;
                    // pointers advance only when their read is issued
                    if (i_x_en) begin
                        state_next.x_ptr = state_reg.x_ptr
                            + step_of(i_x_incr, i_x_incr_value);
                    end
                    if (i_y_en) begin
                        state_next.y_ptr = state_reg.y_ptr
                            + step_of(i_y_incr, i_y_incr_value);
                    end
                end
            end
            AMP_ST_EXEC: begin
                state_next.st = AMP_ST_IDLE;
                state_next.done = 1'h1;
                // write-back uses the other (untargeted) accumulator, written before prefetches
                if (state_reg.wb_en && state_reg.op inside {AMP_OP_MAC, AMP_OP_MOVE}) begin
                    state_next.wreg[state_reg.wb_dest] = acc_other[2*DW-1:DW];
                end
                case (state_reg.op)
                    AMP_OP_MAC, AMP_OP_SQRAC: begin
                        if (state_reg.acc_sel) begin
                            state_next.acc_b = acc_sel_val + prod_ext;
                        end else begin
                            state_next.acc_a = acc_sel_val + prod_ext;
                        end
                    end
                    AMP_OP_SQR: begin
                        if (state_reg.acc_sel) begin
                            state_next.acc_b = prod_ext;
                        end else begin
                            state_next.acc_a = prod_ext;
                        end
                    end
                    AMP_OP_LAC: begin
                        if (state_reg.acc_sel) begin
                            state_next.acc_b = lac_val;
                        end else begin
                            state_next.acc_a = lac_val;
                        end
                    end
                    AMP_OP_FBCL: state_next.result = first_change(opnd_a);
                    AMP_OP_MODS: state_next.result = rem_s[DW-1:0];
                    AMP_OP_MODU: state_next.result = rem_u[DW-1:0];
                    AMP_OP_EXTPAGE: begin
                        state_next.result = DW'(state_reg.ext >> `AMP_EXT_OFS_W);
                    end
                    AMP_OP_EXTOFS: begin
                        state_next.result = DW'(state_reg.ext[`AMP_EXT_OFS_W-1:0]);
                    end
                    AMP_OP_SETXPTR: state_next.x_ptr = state_reg.ptr_val;
                    AMP_OP_SETYPTR: state_next.y_ptr = state_reg.ptr_val;
                    AMP_OP_MOVE: begin
                        // accumulators untouched, only the write-back above and the prefetch transfers below
                        state_next.result = state_reg.result;
                    end
                    default: state_next.result = state_reg.result;
                endcase
                // square ops with both x and y prefetch send the difference to the distance target
                if (state_reg.op == AMP_OP_SQR || state_reg.op == AMP_OP_SQRAC) begin
                    if (state_reg.x_en && state_reg.y_en) begin
                        state_next.wreg[state_reg.x_dest] = diff;
                    end
                end else begin
                    if (state_reg.x_en) begin
                        state_next.wreg[state_reg.x_dest] = i_xmem_data;
                    end
                    if (state_reg.y_en) begin
                        state_next.wreg[state_reg.y_dest] = i_ymem_data;
                    end
                end
            end
            default: state_next.st = AMP_ST_IDLE;
        endcase
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            state_reg <= '0;
            state_reg.st <= AMP_ST_IDLE;
            state_reg.acc_a <= `AMP_ACC_RESET;
            state_reg.acc_b <= `AMP_ACC_RESET;
            state_reg.x_ptr <= `AMP_WORD_RESET;
            state_reg.y_ptr <= `AMP_WORD_RESET;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule // amp_datapath

// >>> verilog/amp_params.svh
// constants for the accumulator datapath
`ifndef AMP_PARAMS_SVH
`define AMP_PARAMS_SVH
`define AMP_DATA_W 16
`define AMP_ACC_W 40
`define AMP_NREG 4
`define AMP_IDX_W 2
`define AMP_INC_CODE_W 3
`define AMP_INC_CODE_REG 3'h7
`define AMP_INC_BIAS 16'h0006
`define AMP_SHIFT_W 4
`define AMP_EXT_ADDR_W 24
`define AMP_EXT_OFS_W 15
`define AMP_ACC_RESET 40'h00_0000_0000
`define AMP_WORD_RESET 16'h0000
`endif

// >>> verilog/amp_pkg.sv
// operation and state types for the accumulator datapath
package amp_pkg;
    // operations issued by the decoder
    typedef enum logic [3:0] {
        AMP_OP_MAC,
        AMP_OP_SQR,
        AMP_OP_SQRAC,
        AMP_OP_LAC,
        AMP_OP_FBCL,
        AMP_OP_MOVE,
        AMP_OP_MODS,
        AMP_OP_MODU,
        AMP_OP_EXTPAGE,
        AMP_OP_EXTOFS,
        AMP_OP_SETXPTR,
        AMP_OP_SETYPTR
    } amp_op_t;
    // sequencer states
    typedef enum logic [0:0] {
        AMP_ST_IDLE,
        AMP_ST_EXEC
    } amp_state_t;
endpackage

// >>> dv/amp_datapath_chk.sv
// port assertions for the accumulator datapath
`timescale 1ns/1ps
`include "amp_params.svh"
module amp_datapath_chk import amp_pkg::*; (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_resetn,
    // issue side
    input wire logic i_op_valid,
    input wire amp_op_t i_op,
    input wire logic i_acc_sel,
    input wire logic i_x_en,
    input wire logic [2:0] i_x_incr,
    input wire logic i_y_en,
    // memory and status side
    input wire logic o_xmem_rd,
    input wire logic [15:0] o_xmem_addr,
    input wire logic o_ymem_rd,
    input wire logic [15:0] o_ymem_addr,
    input wire logic o_ready,
    input wire logic o_done,
    input wire logic [39:0] o_acc_a,
    input wire logic [39:0] o_acc_b
);
    // ****************
    // port relations
    // ****************
    logic take; // request accepted at this edge
    logic pf; // mac and move, whose prefetch is unconditional once asked
    assign take = i_op_valid && o_ready;
    assign pf = i_op inside {AMP_OP_MAC, AMP_OP_MOVE};
    default clocking dc @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);
    a_done_timing: assert property (take |=> !o_ready ##1 o_done ##1 !o_done)
        else $error("done not two edges after accept");
    a_xrd_cause: assert property (o_xmem_rd |-> take && i_x_en)
        else $error("x read without x prefetch");
    a_yrd_cause: assert property (o_ymem_rd |-> take && i_y_en)
        else $error("y read without y prefetch");
    a_xrd_made: assert property (take && pf && i_x_en |-> o_xmem_rd)
        else $error("x prefetch without read");
    a_xptr_hold: assert property (take && !i_x_en && i_op != AMP_OP_SETXPTR
        |=> $stable(o_xmem_addr)) else $error("x pointer moved");
    a_yptr_hold: assert property (take && !i_y_en && i_op != AMP_OP_SETYPTR
        |=> $stable(o_ymem_addr)) else $error("y pointer moved");
    a_xptr_step: assert property (o_xmem_rd && i_x_incr != `AMP_INC_CODE_REG |=>
        o_xmem_addr == $past(o_xmem_addr) + {12'h0, $past(i_x_incr), 1'h0} - `AMP_INC_BIAS)
        else $error("x pointer step wrong");
    a_move_accs: assert property (take && i_op == AMP_OP_MOVE |-> ##2
        o_acc_a == $past(o_acc_a, 2) && o_acc_b == $past(o_acc_b, 2))
        else $error("move changed an accumulator");
    a_one_acc: assert property (take && !i_acc_sel
        && i_op inside {AMP_OP_MAC, AMP_OP_LAC} |-> ##2 o_acc_b == $past(o_acc_b, 2))
        else $error("untargeted accumulator changed");
endmodule // amp_datapath_chk
bind amp_datapath amp_datapath_chk i_amp_datapath_chk (.i_clock, .i_resetn, .i_op_valid,
    .i_op, .i_acc_sel, .i_x_en, .i_x_incr, .i_y_en, .o_xmem_rd, .o_xmem_addr, .o_ymem_rd,
    .o_ymem_addr, .o_ready, .o_done, .o_acc_a, .o_acc_b);

// >>> dv/amp_mem_model.sv
// behavioural x or y data memory on its own read bus
`timescale 1ns/1ps
module amp_mem_model #(
    parameter logic [15:0] MASK = 16'h0000 // stored word is address xor mask
) (
    // clock
    input wire logic i_clock,
    // read bus
    input wire logic i_rd,
    input wire logic [15:0] i_addr,
    output logic [15:0] o_data
);
    // *************
    // read port
    // *************
    // word valid only the cycle after a strobe; otherwise it toggles,
    // so a late sample sees garbage rather than a lucky stale word
    always @(posedge i_clock) begin
        if (i_rd) begin
            o_data <= i_addr ^ MASK;
        end else begin
            o_data <= ~o_data;
        end
    end
endmodule // amp_mem_model

// >>> dv/tb_top.sv
// self-checking bench for the accumulator datapath
`timescale 1ns/1ps
module tb_top import amp_pkg::*; ;
    // ****************
    // stimulus, dut and scenarios
    // ****************
    logic i_clock = 1'h0, i_resetn = 1'h0, i_op_valid = 1'h0, i_acc_sel = 1'h0;
    logic i_x_en = 1'h0, i_y_en = 1'h0, i_wb_en = 1'h0;
    amp_op_t i_op = AMP_OP_MOVE;
    logic [1:0] i_src_a = 2'h0, i_src_b = 2'h0, i_x_dest = 2'h0, i_y_dest = 2'h0;
    logic [1:0] i_wb_dest = 2'h0; // write-back target, set per operation
    logic [2:0] i_x_incr = 3'h3, i_y_incr = 3'h3;
    logic [3:0] i_shift = 4'h0;
    logic [15:0] i_ptr_value = 16'h0, i_x_incr_value = 16'h8, i_y_incr_value = 16'h8;
    logic [23:0] i_ext_addr = 24'h0;
    logic [31:0] i_dividend = 32'h0;
    logic o_xmem_rd, o_ymem_rd, o_ready, o_done;
    logic [15:0] o_xmem_addr, o_ymem_addr, i_xmem_data, i_ymem_data, o_result;
    logic [39:0] o_acc_a, o_acc_b;
    int failures = 0, checks_done = 0;
    always #50 i_clock = ~i_clock;
    amp_datapath i_amp_datapath (.i_clock, .i_resetn, .i_op_valid, .i_op, .i_acc_sel, .i_src_a,
        .i_src_b, .i_shift, .i_dividend, .i_ext_addr, .i_ptr_value, .i_x_en, .i_x_incr,
        .i_x_incr_value, .i_x_dest, .i_y_en, .i_y_incr, .i_y_incr_value, .i_y_dest, .i_wb_en,
        .i_wb_dest, .o_xmem_rd, .o_xmem_addr, .i_xmem_data, .o_ymem_rd, .o_ymem_addr,
        .i_ymem_data, .o_ready, .o_done, .o_result, .o_acc_a, .o_acc_b);
    // x memory holds its address, y memory the inverse, so signs show up
    amp_mem_model #(.MASK(16'h0000)) i_amp_mem_model_x (.i_clock, .i_rd(o_xmem_rd),
        .i_addr(o_xmem_addr), .o_data(i_xmem_data));
    amp_mem_model #(.MASK(16'hffff)) i_amp_mem_model_y (.i_clock, .i_rd(o_ymem_rd),
        .i_addr(o_ymem_addr), .o_data(i_ymem_data));
    function automatic logic [39:0] sx(input logic [15:0] w);
        return {{24{w[15]}}, w};
    endfunction
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'h1) begin
            failures++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one operation; arg carries dests, write-back enable and target, shift, dividend, address
    task automatic go(input amp_op_t o, input logic acc, input logic [1:0] sa,
        input logic [1:0] sb, input logic xe, input logic [2:0] xi, input logic ye,
        input logic [2:0] yi, input logic [31:0] arg);
        @(posedge i_clock);
        i_op <= o;
        i_acc_sel <= acc;
        i_src_a <= sa;
        i_src_b <= sb;
        i_x_en <= xe;
        i_x_incr <= xi;
        i_y_en <= ye;
        i_y_incr <= yi;
        i_x_dest <= arg[5:4];
        i_y_dest <= arg[7:6];
        i_wb_en <= arg[8];
        i_wb_dest <= arg[10:9];
        i_dividend <= arg;
        i_ext_addr <= arg[23:0];
        i_ptr_value <= arg[15:0];
        i_shift <= arg[3:0];
        i_op_valid <= 1'h1;
        @(posedge i_clock);
        i_op_valid <= 1'h0;
        // bounded wait: a hung sequencer ends the run
        for (int n = 0; n < 4 && o_done !== 1'h1; n++) begin
            @(posedge i_clock);
            #1;
        end
        chk(o_done, "done missing");
        if (o_done !== 1'h1) stop_test();
    endtask
    task automatic t_prefetch();
        go(AMP_OP_SETXPTR, 0, 0, 0, 0, 3, 0, 3, 32'h10);
        go(AMP_OP_SETYPTR, 0, 0, 0, 0, 3, 0, 3, 32'h20);
        go(AMP_OP_MOVE, 0, 0, 0, 1, 5, 1, 0, 32'h40); // x to reg0 by +4, y to reg1 by -6
        chk(o_xmem_addr === 16'h0014 && o_ymem_addr === 16'h001a, "steps");
        chk(o_acc_a === 40'h0 && o_acc_b === 40'h0, "move accs");
        go(AMP_OP_LAC, 0, 0, 0, 0, 3, 0, 3, 32'h0);
        chk(o_acc_a === sx(16'h0010), "x word");
        go(AMP_OP_LAC, 1, 1, 0, 0, 3, 0, 3, 32'h0);
        chk(o_acc_b === sx(16'hffdf) && o_acc_a === sx(16'h10), "y word");
        go(AMP_OP_MOVE, 0, 0, 0, 0, 6, 0, 6, 32'h5a0); // no prefetch, b written back to reg2
        chk(o_xmem_addr === 16'h0014 && o_ymem_addr === 16'h001a, "held");
        go(AMP_OP_LAC, 0, 2, 0, 0, 3, 0, 3, 32'h0);
        chk(o_acc_a === sx(16'hffff), "write-back");
        go(AMP_OP_MAC, 1, 0, 1, 1, 3, 0, 3, 32'h0); // reg0 refetched under the multiply
        chk(o_acc_b === sx(16'hffdf) + 40'hff_ffff_fdf0, "mac sum");
        go(AMP_OP_LAC, 0, 0, 0, 0, 3, 0, 3, 32'h0);
        chk(o_acc_a === sx(16'h0014), "mac prefetch");
    endtask
    task automatic t_steps();
        logic [15:0] xp;
        xp = 16'h0100;
        go(AMP_OP_SETXPTR, 0, 0, 0, 0, 3, 0, 3, 32'h100);
        for (int c = 0; c < 8; c++) begin
            go(AMP_OP_MOVE, 0, 0, 0, 1, 3'(c), 0, 3, 32'h30);
            xp = xp + ((c == 7) ? 16'h0008 : 16'(2 * c - 6));
            chk(o_xmem_addr === xp, "step code");
        end
    endtask
    task automatic t_sqrac();
        go(AMP_OP_SETXPTR, 0, 0, 0, 0, 3, 0, 3, 32'h30);
        go(AMP_OP_SETYPTR, 0, 0, 0, 0, 3, 0, 3, 32'h5);
        go(AMP_OP_SQRAC, 0, 0, 0, 1, 5, 1, 5, 32'h30); // distance into reg3
        chk(o_acc_a === 40'h1a4, "square sum");
        go(AMP_OP_LAC, 1, 3, 0, 0, 3, 0, 3, 32'h0);
        chk(o_acc_b === 40'h36, "distance");
        go(AMP_OP_SQR, 1, 3, 0, 1, 3, 1, 3, 32'h0); // square reg3 into b, distance into reg0
        chk(o_acc_b === 40'hb64 && o_acc_a === 40'h1a4, "square");
        go(AMP_OP_LAC, 0, 0, 0, 0, 3, 0, 3, 32'h0);
        chk(o_acc_a === 40'h3e, "second distance");
    endtask
    task automatic t_lac();
        logic signed [39:0] v;
        logic [3:0] s;
        for (int k = 0; k < 3; k++) begin
            s = (k == 0) ? 4'h8 : (k == 1) ? 4'h7 : 4'hd;
            v = sx(16'hffdf);
            v = s[3] ? v <<< (5'h10 - s) : v >>> s;
            go(AMP_OP_LAC, 0, 1, 0, 0, 3, 0, 3, {28'h0, s});
            chk(o_acc_a === v, "lac shift");
        end
    endtask
    task automatic t_fbcl();
        // expected position from the msb end; 16 when every bit equals the sign
        logic [15:0] vals [4] = '{16'h0000, 16'h0010, 16'h8000, 16'hfff0};
        logic [15:0] e [4] = '{16'h0010, 16'h000b, 16'h0001, 16'h000c};
        foreach (vals[k]) begin
            go(AMP_OP_SETXPTR, 0, 0, 0, 0, 3, 0, 3, {16'h0, vals[k]});
            go(AMP_OP_MOVE, 0, 0, 0, 1, 3, 0, 3, 32'h0);
            go(AMP_OP_FBCL, 0, 0, 0, 0, 3, 0, 3, 32'h0);
            chk(o_result === e[k], "bit change");
        end
    endtask
    task automatic t_div_ext();
        go(AMP_OP_SETXPTR, 0, 0, 0, 0, 3, 0, 3, 32'h7);
        go(AMP_OP_MOVE, 0, 0, 0, 1, 3, 0, 3, 32'h0);
        go(AMP_OP_MODU, 0, 0, 0, 0, 3, 0, 3, 32'h0001_0006);
        chk(o_result === 16'h0001, "unsigned remainder");
        go(AMP_OP_MODS, 0, 0, 0, 0, 3, 0, 3, 32'hffff_ff9c);
        chk(o_result === 16'hfffe, "signed remainder");
        go(AMP_OP_EXTPAGE, 0, 0, 0, 0, 3, 0, 3, 32'h12_3456);
        chk(o_result === 16'h0024, "page");
        go(AMP_OP_EXTOFS, 0, 0, 0, 0, 3, 0, 3, 32'h12_3456);
        chk(o_result === 16'h3456, "offset");
    endtask
    initial begin
        repeat (10) @(posedge i_clock);
        i_resetn <= 1'h1;
        #1;
        chk(o_ready === 1'h1 && o_done === 1'h0 && o_acc_a === 40'h0, "reset state");
        t_prefetch();
        t_steps();
        t_sqrac();
        t_lac();
        t_fbcl();
        t_div_ext();
        stop_test();
    end
endmodule // tb_top
